// ---- rtl/line_mode_ext.v ----
// line-mode extensions: infrared codec, rs485/modem pins, channel test modes
`timescale 1ns/100ps
`include "line_mode_regs.vh"

module line_mode_ext (
  input wire clk,
  input wire rst_n,
  // line mode and channel test configuration settings
  input wire [3:0] line_mode,
  input wire [1:0] channel_mode,
  input wire [7:0] infrared_filter,
  input wire [15:0] bit_period_clks,
  // transmitter side of the character engine
  input wire tx_serial,
  input wire tx_busy_char,
  input wire transmitter_idle_flag,
  // one-cycle command and status read strobes
  input wire rts_cmd_on,
  input wire rts_cmd_off,
  input wire terminal_ready_on_cmd,
  input wire terminal_ready_off_cmd,
  input wire status_read,
  // line and modem pins, all active low except the data pins
  input wire rxd_pin,
  input wire ring_n,
  input wire set_ready_n,
  input wire carrier_n,
  input wire clear_send_n,
  // pins towards the line and the receiver, registered except the two enable gates
  output reg txd_pin,
  output reg rx_serial,
  output reg rts_n,
  output reg terminal_ready_n,
  output reg ring_change_flag,
  output reg set_ready_change_flag,
  output reg carrier_change_flag,
  output reg clear_send_change_flag,
  output reg tx_allowed,
  output wire tx_enable_gate,
  output wire rx_enable_gate
);

  // decoded modes
  wire infrared_mode = (line_mode == `LM_MODE_INFRARED);
  wire rs485_mode = (line_mode == `LM_MODE_RS485);
  wire modem_mode = (line_mode == `LM_MODE_MODEM);
  wire hs_mode = (line_mode == `LM_MODE_HANDSHAKE);

  // pulse length of 3/16 bit period, at least one cycle
  function [15:0] pulse_len;
    input [15:0] period;
    reg [19:0] prod;
    begin
      prod = {`PAD_ZERO, period} * `PULSE_NUM;
      pulse_len = prod[19:`PULSE_DEN_SHIFT];
      if (pulse_len == `DIV_ZERO)
        pulse_len = `DIV_ONE;
    end
  endfunction

  // sticky change flag: a new change wins over the clearing read
  function sticky_next;
    input chg;
    input old;
    input rd;
    begin
      sticky_next = chg | (old & ~rd);
    end
  endfunction

  // ---------------- modulator ----------------
  // the modulator sees only the serial bit stream, not the framing.
  // a bit timer restarts at every level change of the transmitter
  // output, so each zero bit opens one short light pulse at its start.
  // a run of zero bits has no edge between them; the timer then wraps
  // at the programmed bit length and opens the next pulse by itself.
  // a very short bit period still gives a pulse of one clock.
  reg tx_prev_reg;
  reg [15:0] bit_cnt_reg;
  reg [15:0] bit_cnt_next;
  reg ir_tx_reg;
  reg ir_tx_next;

  // bit timer restarts on each transmit edge, pulse lasts 3/16 bit
  always @* begin
    bit_cnt_next = bit_cnt_reg;
    ir_tx_next = 1'b1;
    if (tx_serial != tx_prev_reg)
      bit_cnt_next = `DIV_ZERO;
    else if (bit_cnt_reg >= bit_period_clks - `DIV_ONE)
      bit_cnt_next = `DIV_ZERO;
    else
      bit_cnt_next = bit_cnt_reg + `DIV_ONE;
    if (!tx_serial && bit_cnt_next < pulse_len(bit_period_clks))
      ir_tx_next = 1'b0;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_prev_reg <= 1'b1;
      bit_cnt_reg <= `DIV_ZERO;
      ir_tx_reg <= 1'b1;
    end else begin
      tx_prev_reg <= tx_serial;
      bit_cnt_reg <= bit_cnt_next;
      ir_tx_reg <= ir_tx_next;
    end
  end

  // ---------------- demodulator ----------------
  // a light pulse shows as a low level on the receive pin.
  // the filter counter runs from the falling edge, once per clock.
  // a rising edge before it empties marks a glitch: the counter
  // stops, reloads, and nothing reaches the receiver.
  // when it empties first, the receiver input is held low for one
  // full bit period, which the receiver samples as a zero bit.
  // the reload value is read at each load, so a new filter setting
  // takes effect on the next pulse, never in the middle of one.
  // a rising edge with the counter idle is ignored.
  reg rx_prev_reg;
  reg [7:0] filt_cnt_reg;
  reg [7:0] filt_cnt_next;
  reg filt_run_reg;
  reg filt_run_next;
  reg [15:0] low_cnt_reg;
  reg [15:0] low_cnt_next;
  reg ir_rx_reg;
  reg ir_rx_next;

  // filter counter and one-bit low stretch
  always @* begin
    filt_cnt_next = filt_cnt_reg;
    filt_run_next = filt_run_reg;
    low_cnt_next = low_cnt_reg;
    ir_rx_next = ir_rx_reg;
    if (rx_prev_reg && !rxd_pin) begin
      filt_run_next = 1'b1;
      filt_cnt_next = infrared_filter;
    end else if (!rx_prev_reg && rxd_pin && filt_run_reg) begin
      filt_run_next = 1'b0;
      filt_cnt_next = infrared_filter;
    end else if (filt_run_reg) begin
      if (filt_cnt_reg == `FILTER_ZERO) begin
        filt_run_next = 1'b0;
        filt_cnt_next = infrared_filter;
        ir_rx_next = 1'b0;
        low_cnt_next = bit_period_clks;
      end else begin
        filt_cnt_next = filt_cnt_reg - `FILTER_STEP;
      end
    end
    if (!ir_rx_reg) begin
      if (low_cnt_reg <= `DIV_ONE)
        ir_rx_next = 1'b1;
      else
        low_cnt_next = low_cnt_reg - `DIV_ONE;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_reg <= 1'b1;
      filt_cnt_reg <= `FILTER_ZERO;
      filt_run_reg <= 1'b0;
      low_cnt_reg <= `DIV_ZERO;
      ir_rx_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rxd_pin;
      filt_cnt_reg <= filt_cnt_next;
      filt_run_reg <= filt_run_next;
      low_cnt_reg <= low_cnt_next;
      ir_rx_reg <= ir_rx_next;
    end
  end

  // ---------------- path selection ----------------
  // character framing stays outside, only line bits are swapped
  wire tx_line = infrared_mode ? ir_tx_reg : tx_serial;
  wire rx_line = infrared_mode ? ir_rx_reg : rxd_pin;

  reg txd_next;
  reg rx_next;

  // channel configuration routing
  // echo and remote loopback pass the raw pin, never the demodulated
  // level, so the far end sees its own bits back unchanged.
  // local loopback feeds the raw transmitter bits, with no infrared
  // coding in between, and parks the transmit pin at idle high.
  always @* begin
    txd_next = tx_line;
    rx_next = rx_line;
    case (channel_mode)
      `CH_NORMAL: begin
        txd_next = tx_line;
        rx_next = rx_line;
      end
      `CH_ECHO: begin
        txd_next = rxd_pin;
        rx_next = rx_line;
      end
      `CH_LOCAL: begin
        txd_next = 1'b1;
        rx_next = tx_serial;
      end
      `CH_REMOTE: begin
        txd_next = rxd_pin;
        rx_next = 1'b1;
      end
      default: begin
        txd_next = tx_line;
        rx_next = rx_line;
      end
    endcase
  end

  // pins and receiver input come from flip-flops, reset to idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd_pin <= 1'b1;
      rx_serial <= 1'b1;
    end else begin
      txd_pin <= txd_next;
      rx_serial <= rx_next;
    end
  end

  // remote loopback disables both ends, echo keeps rx open and leaves the tx gate to tx_allowed
  assign tx_enable_gate = (channel_mode != `CH_REMOTE) && tx_allowed;
  assign rx_enable_gate = (channel_mode != `CH_REMOTE);

  // ---------------- modem inputs ----------------
  // each input is compared with its level one clock earlier.
  // the first clock after reset only captures the levels, so a pin
  // that rests low from power-up does not raise a false change.
  // the flags stay set until a status read, and a change that falls
  // into the read cycle is kept rather than lost.
  reg [3:0] in_prev_reg;
  reg in_valid_reg;
  wire [3:0] in_now = {ring_n, set_ready_n, carrier_n, clear_send_n};
  wire [3:0] in_chg = in_valid_reg ? (in_now ^ in_prev_reg) :
    `NO_CHANGE;

  // change flags: a change in the read cycle wins over the clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prev_reg <= `MODEM_IDLE;
      in_valid_reg <= 1'b0;
      ring_change_flag <= 1'b0;
      set_ready_change_flag <= 1'b0;
      carrier_change_flag <= 1'b0;
      clear_send_change_flag <= 1'b0;
    end else begin
      in_prev_reg <= in_now;
      in_valid_reg <= 1'b1;
      ring_change_flag <= sticky_next(in_chg[3], ring_change_flag,
        status_read);
      set_ready_change_flag <= sticky_next(in_chg[2],
        set_ready_change_flag, status_read);
      carrier_change_flag <= sticky_next(in_chg[1], carrier_change_flag,
        status_read);
      clear_send_change_flag <= sticky_next(in_chg[0],
        clear_send_change_flag, status_read);
    end
  end

  // transmitter gate from clear-to-send, held until character ends.
  // cutting a character in half would corrupt it on the line, so an
  // inactive clear-to-send only closes the gate between characters.
  // the gate reopens at once when clear-to-send returns low.
  // handshake mode shares this gating; other modes leave it open.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_allowed <= 1'b1;
    end else if (modem_mode || hs_mode) begin
      if (!clear_send_n)
        tx_allowed <= 1'b1;
      else if (!tx_busy_char)
        tx_allowed <= 1'b0;
    end else begin
      tx_allowed <= 1'b1;
    end
  end

  // ---------------- output pins ----------------
  // terminal ready latch; off wins if both commands arrive together.
  // the pin rests inactive high from reset until software enables it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      terminal_ready_n <= 1'b1;
    end else if (terminal_ready_off_cmd) begin
      terminal_ready_n <= 1'b1;
    end else if (terminal_ready_on_cmd) begin
      terminal_ready_n <= 1'b0;
    end
  end

  // request to send: rs485 follows idle, modem automatic, else commands.
  // in rs485 mode the pin is the line driver enable: it stays high
  // while the transmitter is busy or inside its timeguard, so the bus
  // stays driven until the idle flag rises.
  // in modem mode the pin goes active low while the transmitter works.
  // the plain commands only act in the remaining modes.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else if (rs485_mode) begin
      rts_n <= ~transmitter_idle_flag;
    end else if (modem_mode) begin
      rts_n <= transmitter_idle_flag;
    end else if (rts_cmd_off) begin
      rts_n <= 1'b1;
    end else if (rts_cmd_on) begin
      rts_n <= 1'b0;
    end
  end

endmodule

// ---- rtl/line_mode_regs.vh ----
// constants for the serial line-mode extension block
`ifndef LINE_MODE_REGS_VH
`define LINE_MODE_REGS_VH
`define LM_MODE_NORMAL 4'h0
`define LM_MODE_RS485 4'h1
`define LM_MODE_HANDSHAKE 4'h2
`define LM_MODE_MODEM 4'h3
`define LM_MODE_INFRARED 4'h8
`define CH_NORMAL 2'h0
`define CH_ECHO 2'h1
`define CH_LOCAL 2'h2
`define CH_REMOTE 2'h3
`define FILTER_ZERO 8'h00
`define DIV_ZERO 16'h0000
`define DIV_ONE 16'h0001
`define PULSE_NUM 20'h00003
`define PULSE_DEN_SHIFT 4
`define FILTER_STEP 8'h01
`define MODEM_IDLE 4'hf
`define NO_CHANGE 4'h0
`define PAD_ZERO 4'h0
`endif

// ---- bench/ir_partner.sv ----
// infrared transmitter model: sends light pulses of a set length onto rxd
`timescale 1ns/100ps
module ir_partner (
  input wire clk,
  input wire go,
  input wire [7:0] width,
  output wire rxd
);
  reg [7:0] left_reg = 8'h00;
  // line is pulled up whenever no light is seen
  assign rxd = (left_reg == 8'h00);
  // count down the pulse length once started
  always @(posedge clk) begin
    if (go)
      left_reg <= width;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end
endmodule

// ---- bench/line_mode_monitor.sv ----
// assertion checker for the line-mode extension block
`timescale 1ns/100ps
module line_mode_monitor (
  input wire clk, rst_n, tx_serial, tx_busy_char, transmitter_idle_flag,
  input wire terminal_ready_off_cmd, rxd_pin, ring_n, clear_send_n,
  input wire txd_pin, rx_serial, rts_n, terminal_ready_n,
  input wire ring_change_flag, tx_allowed, tx_enable_gate, rx_enable_gate,
  input wire [3:0] line_mode,
  input wire [1:0] channel_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pin paths for the four channel configurations
  property p_norm;
    line_mode == 4'h0 && channel_mode == 2'h0 |=>
      txd_pin == $past(tx_serial) && rx_serial == $past(rxd_pin);
  endproperty
  a_norm: assert property (p_norm) else $error("normal path");
  property p_echo;
    line_mode == 4'h0 && channel_mode == 2'h1 |=> txd_pin == $past(rxd_pin);
  endproperty
  a_echo: assert property (p_echo) else $error("echo path");
  property p_loc;
    channel_mode == 2'h2 |=> txd_pin && rx_serial == $past(tx_serial);
  endproperty
  a_loc: assert property (p_loc) else $error("local loop");
  property p_rem;
    channel_mode == 2'h3 |-> !tx_enable_gate && !rx_enable_gate ##1
      txd_pin == $past(rxd_pin);
  endproperty
  a_rem: assert property (p_rem) else $error("remote loop");
  // line driver and modem pins
  property p_rs;
    line_mode == 4'h1 |=> rts_n == !$past(transmitter_idle_flag);
  endproperty
  a_rs: assert property (p_rs) else $error("driver enable");
  property p_dtr;
    terminal_ready_off_cmd |=> terminal_ready_n;
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready");
  property p_chg;
    $changed(ring_n) |=> ring_change_flag;
  endproperty
  a_chg: assert property (p_chg) else $error("ring change");
  property p_cts;
    line_mode == 4'h3 && clear_send_n && !tx_busy_char |=> !tx_allowed;
  endproperty
  a_cts: assert property (p_cts) else $error("clear to send");
endmodule
bind line_mode_ext line_mode_monitor mon_u (.*);

// ---- bench/testbench.sv ----
// self-checking bench for the line-mode extension block
`timescale 1ns/100ps
module testbench;
  reg clk, rst_n, tx_serial, tx_busy_char, transmitter_idle_flag, go;
  reg terminal_ready_on_cmd, terminal_ready_off_cmd, status_read;
  reg ring_n, set_ready_n, carrier_n, clear_send_n;
  reg [3:0] line_mode;
  reg [1:0] channel_mode;
  reg [7:0] width;
  wire rxd_pin, txd_pin, rx_serial, rts_n, terminal_ready_n, tx_allowed;
  wire ring_change_flag, set_ready_change_flag, carrier_change_flag;
  wire clear_send_change_flag, tx_enable_gate, rx_enable_gate;
  integer bad_count, n_compared, i, c, lo_tx, lo_rx;
  line_mode_ext dut_u (.*, .infrared_filter(8'h05),
    .bit_period_clks(16'h0014), .rts_cmd_on(1'b0), .rts_cmd_off(1'b0));
  ir_partner far_u (.clk(clk), .go(go), .width(width), .rxd(rxd_pin));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // walk all channel configurations with transmitter and pin opposed
  task t_channel;
    for (c = 0; c < 4; c = c + 1) begin
      channel_mode = c[1:0];
      tx_serial = 1'b0;
      tick(2);
      chk(txd_pin, c != 0);
      chk(rx_serial, c != 2);
      chk({tx_enable_gate, rx_enable_gate}, c == 3 ? 0 : 3);
      tx_serial = 1'b1;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(1);
      chk(txd_pin, !c[0]);
      chk(rx_serial, c[1]);
      tick(10);
    end
    channel_mode = 2'h0;
  endtask
  // driver enable, terminal ready, change flags and clear-to-send
  task t_modem;
    begin
      line_mode = 4'h1;
      transmitter_idle_flag = 1'b0;
      tick(2);
      chk(rts_n, 1);
      line_mode = 4'h3;
      terminal_ready_on_cmd = 1'b1;
      tick(1);
      chk(rts_n, 0);
      terminal_ready_on_cmd = 1'b0;
      terminal_ready_off_cmd = 1'b1;
      chk(terminal_ready_n, 0);
      tick(1);
      terminal_ready_off_cmd = 1'b0;
      chk(terminal_ready_n, 1);
      tx_busy_char = 1'b1;
      {ring_n, set_ready_n, carrier_n, clear_send_n} = 4'h1;
      tick(1);
      chk({ring_change_flag, set_ready_change_flag, carrier_change_flag,
        clear_send_change_flag}, 4'hf);
      status_read = 1'b1;
      tick(1);
      status_read = 1'b0;
      chk({ring_change_flag, set_ready_change_flag, carrier_change_flag,
        clear_send_change_flag, tx_allowed}, 5'h01);
      tx_busy_char = 1'b0;
      tick(1);
      chk(tx_allowed, 0);
      clear_send_n = 1'b0;
    end
  endtask
  // infrared: light pulse of w clocks, optional zero bit on transmit
  task t_ir(input [7:0] w, input [15:0] rx_lo, input [15:0] tx_lo);
    begin
      line_mode = 4'h8;
      width = w;
      go = 1'b1;
      tx_serial = 1'b1;
      lo_tx = 0;
      lo_rx = 0;
      tick(1);
      go = 1'b0;
      for (i = 0; i < 60; i = i + 1) begin
        if (i == 30)
          tx_serial = tx_lo == 0;
        if (i == 45)
          tx_serial = 1'b1;
        lo_tx = lo_tx + !txd_pin;
        lo_rx = lo_rx + !rx_serial;
        tick(1);
      end
      chk(lo_rx, rx_lo);
      chk(lo_tx, tx_lo);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, line_mode, channel_mode, tx_busy_char, go, status_read} = 0;
    {terminal_ready_on_cmd, terminal_ready_off_cmd} = 2'h0;
    {tx_serial, transmitter_idle_flag, width} = 10'h208;
    {ring_n, set_ready_n, carrier_n, clear_send_n} = 4'he;
    bad_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(2);
    t_channel;
    t_modem;
    t_ir(8'h03, 16'h0000, 16'h0000);
    t_ir(8'h0c, 16'h0014, 16'h0003);
    stop_test;
  end
endmodule
